// [inc/flash_host_pkg.sv]
// constants for the host that drives a parallel flash through its pins
// assumes a 20 MHz core clock and a software port with 32-bit data
package flash_host_pkg;
    localparam int CLK_NS      = 50;
    localparam int T_SETUP_NS  = 50;
    localparam int T_STROBE_NS = 100;
    localparam int T_GAP_NS    = 50;
    localparam int SETUP_CYC   = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC     = (T_GAP_NS + CLK_NS - 1) / CLK_NS;

    // software register offsets
    localparam logic [7:0] REG_CMD  = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam logic [7:0] REG_IRQ  = 8'h10;
    localparam logic [7:0] REG_MASK = 8'h14;

    // operation codes written to the command register, bits 2:0
    localparam logic [2:0] OP_PROG   = 3'h1;
    localparam logic [2:0] OP_ERASE  = 3'h2;
    localparam logic [2:0] OP_SUSP   = 3'h3;
    localparam logic [2:0] OP_RESUME = 3'h4;
    localparam logic [2:0] OP_CLEAR  = 3'h5;
    localparam logic [2:0] OP_RDSTAT = 3'h6;

    // command words sent on the data pins
    localparam logic [15:0] FL_RDSR    = 16'h0070;
    localparam logic [15:0] FL_CLR     = 16'h0050;
    localparam logic [15:0] FL_PROG    = 16'h0040;
    localparam logic [15:0] FL_ERASE   = 16'h0020;
    localparam logic [15:0] FL_CONFIRM = 16'h00D0;
    localparam logic [15:0] FL_SUSP    = 16'h00B0;
    localparam logic [15:0] FL_RESUME  = 16'h00D0;

    // device status byte layout
    localparam int SR_READY  = 7;
    localparam int SR_ESUSP  = 6;
    localparam int SR_PSUSP  = 2;
    localparam int SR_RSVD   = 0;
    localparam logic [7:0] SR_STICKY = 8'h3A;
    localparam logic [7:0] STAT_RST  = 8'h00;

    // host status register and event bits
    localparam int STAT_BUSY   = 8;
    localparam int STAT_STICKY = 9;
    localparam int EV_DONE     = 0;
    localparam int EV_ERR      = 1;
    localparam int EV_SUSP     = 2;
    localparam int EV_W        = 3;
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;

    function automatic logic sr_sticky(input logic [7:0] s);
        return |(s & SR_STICKY);
    endfunction

    function automatic logic sr_paused(input logic [7:0] s);
        return s[SR_PSUSP] | s[SR_ESUSP];
    endfunction
endpackage

// [rtl/event_irq.sv]
// sticky event bits, write-one-to-clear, mask and level interrupt
// assumes event inputs are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module event_irq
    import flash_host_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            rst,
    input  wire logic [EV_W-1:0] ev,
    input  wire logic            clr_wr,
    input  wire logic            mask_wr,
    input  wire logic [EV_W-1:0] wdata,
    output logic [EV_W-1:0]      stat,
    output logic [EV_W-1:0]      mask,
    output logic                 irq
);
    logic [EV_W-1:0] st_q, st_d, mk_q, mk_d;
    logic            irq_q, irq_d;

    always_comb
    begin
        // a new event beats a clear in the same cycle
        st_d  = (st_q & ~(clr_wr ? wdata : '0)) | ev;
        mk_d  = mask_wr ? wdata : mk_q;
        irq_d = |(st_d & mk_d);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_q <= '0; mk_q <= MASK_RST; irq_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d; mk_q <= mk_d; irq_q <= irq_d;
        end
    end

    assign stat = st_q; assign mask = mk_q; assign irq = irq_q;

    irq_level_a: assert property (@(posedge core_clk) disable iff (rst)
        irq == |(stat & mask))
        else $error("interrupt level disagrees with status and mask");
endmodule // event_irq
`default_nettype wire

// [rtl/flash_host.sv]
// host controller for a parallel flash: commands, status polling, errors
// assumes the flash pins are sampled on core_clk; software port never waits
`timescale 1ns/100ps
`default_nettype none
module flash_host
    import flash_host_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             irq,
    output logic [19:0]      flash_addr,
    input  wire logic [15:0] dq_in,
    output logic [15:0]      dq_out,
    output logic             dq_oe,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic             rp_n
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_CLR, ST_CMD1, ST_CMD2, ST_POLL, ST_SUSP
    } state_t;

    state_t      state_q, state_d;
    logic        wait_q, wait_d;
    logic [2:0]  op_q, op_d;
    logic        sticky_q, sticky_d;
    logic        spend_q, spend_d;
    logic        busy_q, busy_d;
    logic [7:0]  stat_q, stat_d;
    logic [19:0] addr_q, addr_d;
    logic [15:0] data_q, data_d;
    logic        rp_n_q;
    logic [31:0] rdata_q, rdata_d;

    logic        cyc_req, cyc_wr, cyc_ack;
    logic [15:0] cyc_wdata, cyc_rdata;
    logic [EV_W-1:0] ev, irq_stat, irq_mask;
    logic        cmd_wr;
    logic [2:0]  cmd_op;
    logic [7:0]  sr;

    assign cmd_wr = reg_wr && reg_addr == REG_CMD;
    assign cmd_op = reg_wdata[2:0];
    assign sr     = cyc_rdata[7:0];

    flash_pin_cycle u_cycle (
        .core_clk (core_clk),
        .rst      (rst),
        .req      (cyc_req),
        .wr       (cyc_wr),
        .addr     (addr_q),
        .wdata    (cyc_wdata),
        .ack      (cyc_ack),
        .rdata    (cyc_rdata),
        .pin_addr (flash_addr),
        .dq_in    (dq_in),
        .dq_out   (dq_out),
        .dq_oe    (dq_oe),
        .ce_n     (ce_n),
        .oe_n     (oe_n),
        .we_n     (we_n)
    );

    event_irq u_irq (
        .core_clk (core_clk),
        .rst      (rst),
        .ev       (ev),
        .clr_wr   (reg_wr && reg_addr == REG_IRQ),
        .mask_wr  (reg_wr && reg_addr == REG_MASK),
        .wdata    (reg_wdata[EV_W-1:0]),
        .stat     (irq_stat),
        .mask     (irq_mask),
        .irq      (irq)
    );

    // command sequencer
    always_comb
    begin
        state_d = state_q; wait_d = wait_q; op_d = op_q;
        sticky_d = sticky_q; spend_d = spend_q; busy_d = busy_q;
        stat_d = stat_q; addr_d = addr_q; data_d = data_q;
        cyc_req = 1'b0; cyc_wr = 1'b1; cyc_wdata = FL_RDSR;
        ev = '0;
        if (reg_wr && reg_addr == REG_ADDR && !busy_q)
            addr_d = reg_wdata[19:0];
        if (reg_wr && reg_addr == REG_DATA && !busy_q)
            data_d = reg_wdata[15:0];
        if (state_q != ST_IDLE)
            cyc_req = !wait_q;
        if (cyc_req)
            wait_d = 1'b1;
        if (cyc_ack)
            wait_d = 1'b0;
        unique case (state_q)
            ST_IDLE:
                if (cmd_wr)
                begin
                    op_d = cmd_op;
                    // a suspend asked as the last poll ended must not hit this op
                    spend_d = 1'b0;
                    busy_d = 1'b1;
                    if (cmd_op == OP_CLEAR)
                        state_d = ST_CLR;
                    else if (cmd_op == OP_RDSTAT)
                        state_d = ST_POLL;
                    else if (cmd_op == OP_PROG || cmd_op == OP_ERASE
                             || cmd_op == OP_SUSP || cmd_op == OP_RESUME)
                        // a stale error would make the new command fail
                        state_d = sticky_q ? ST_CLR : ST_CMD1;
                    else
                        busy_d = 1'b0;
                end
            ST_CLR:
            begin
                cyc_wdata = FL_CLR;
                if (cyc_ack)
                begin
                    // one command drops every error flag at once
                    sticky_d = 1'b0;
                    stat_d = stat_q & ~SR_STICKY;
                    state_d = (op_q == OP_CLEAR) ? ST_IDLE : ST_CMD1;
                    busy_d = op_q != OP_CLEAR;
                end
            end
            ST_CMD1:
            begin
                unique case (op_q)
                    OP_PROG:  cyc_wdata = FL_PROG;
                    OP_ERASE: cyc_wdata = FL_ERASE;
                    OP_SUSP:  cyc_wdata = FL_SUSP;
                    default:  cyc_wdata = FL_RESUME;
                endcase
                if (cyc_ack)
                    state_d = (op_q == OP_PROG || op_q == OP_ERASE)
                              ? ST_CMD2 : ST_POLL;
            end
            ST_CMD2:
            begin
                cyc_wdata = (op_q == OP_PROG) ? data_q : FL_CONFIRM;
                if (cyc_ack)
                    state_d = ST_POLL;
            end
            ST_SUSP:
            begin
                cyc_wdata = FL_SUSP;
                if (cyc_ack)
                begin
                    spend_d = 1'b0;
                    state_d = ST_POLL;
                end
            end
            ST_POLL:
            begin
                // reads at the operation address return status while busy
                cyc_wr = 1'b0;
                if (cyc_ack)
                begin
                    if (!sr[SR_READY])
                    begin
                        // keep polling; suspend goes out between two reads
                        if (spend_q)
                            state_d = ST_SUSP;
                    end
                    else
                    begin
                        // flags are only trusted once ready reads high
                        stat_d = sr & ~(8'h01 << SR_RSVD);
                        sticky_d = sticky_q | sr_sticky(sr);
                        ev[EV_ERR]  = sr_sticky(sr);
                        // a late suspend may find the program finished
                        ev[EV_SUSP] = sr_paused(sr);
                        ev[EV_DONE] = !sr_sticky(sr) && !sr_paused(sr);
                        spend_d = 1'b0;
                        busy_d = 1'b0;
                        state_d = ST_IDLE;
                    end
                end
            end
        endcase
        if (cmd_wr && cmd_op == OP_SUSP && state_q == ST_POLL)
            spend_d = 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE; wait_q <= 1'b0; op_q <= 3'h0;
            // device reset pin held low with ours, flags start low
            sticky_q <= 1'b0; stat_q <= STAT_RST;
            spend_q <= 1'b0; busy_q <= 1'b0;
            addr_q <= 20'h00000; data_q <= 16'h0000; rp_n_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d; wait_q <= wait_d; op_q <= op_d;
            sticky_q <= sticky_d; stat_q <= stat_d;
            spend_q <= spend_d; busy_q <= busy_d;
            addr_q <= addr_d; data_q <= data_d; rp_n_q <= 1'b1;
        end
    end

    assign rp_n = rp_n_q;

    // software read port, answer one cycle after the strobe
    always_comb
    begin
        rdata_d = 32'h00000000;
        if (reg_rd)
        begin
            unique case (reg_addr)
                REG_CMD:  rdata_d = {29'h0, op_q};
                REG_ADDR: rdata_d = {12'h000, addr_q};
                REG_DATA: rdata_d = {16'h0000, data_q};
                REG_STAT: rdata_d = {22'h0, sticky_q, busy_q, stat_q};
                REG_IRQ:  rdata_d = {29'h0, irq_stat};
                REG_MASK: rdata_d = {29'h0, irq_mask};
                default:  rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            rdata_q <= 32'h00000000;
        else
            rdata_q <= rdata_d;
    end

    assign reg_rdata = rdata_q;

    clear_first_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == ST_CMD1 && cyc_req |-> !sticky_q)
        else $error("operation started with an error flag still set");

    clear_route_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == ST_IDLE && cmd_wr && sticky_q && cmd_op == OP_PROG
        |=> state_q == ST_CLR ##1 (state_q == ST_CLR) [*1])
        else $error("pending error not cleared before a new command");

    ready_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(sticky_q) |-> $past(cyc_ack && !cyc_wr && cyc_rdata[SR_READY]))
        else $error("error flag taken while the device was busy");

    rsvd_mask_a: assert property (@(posedge core_clk) disable iff (rst)
        stat_q[SR_RSVD] == 1'b0)
        else $error("reserved status bit passed to software");

    reg_read_a: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == REG_STAT |=> reg_rdata[STAT_BUSY] == $past(busy_q))
        else $error("status read answer not one cycle late");

    done_cov: cover property (@(posedge core_clk) disable iff (rst)
        ev[EV_DONE] && op_q == OP_PROG);
    susp_cov: cover property (@(posedge core_clk) disable iff (rst)
        ev[EV_SUSP]);
    err_cov: cover property (@(posedge core_clk) disable iff (rst)
        state_q == ST_CLR && op_q == OP_ERASE && cyc_ack);
endmodule // flash_host
`default_nettype wire

// [rtl/flash_pin_cycle.sv]
// one asynchronous bus cycle on the flash pins, write or read
// assumes dq_in synchronous to core_clk; one request at a time
`timescale 1ns/100ps
`default_nettype none
module flash_pin_cycle
    import flash_host_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        req,
    input  wire logic        wr,
    input  wire logic [19:0] addr,
    input  wire logic [15:0] wdata,
    output logic             ack,
    output logic [15:0]      rdata,
    output logic [19:0]      pin_addr,
    input  wire logic [15:0] dq_in,
    output logic [15:0]      dq_out,
    output logic             dq_oe,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n
);
    typedef enum logic [1:0] {P_IDLE, P_SETUP, P_STROBE, P_GAP} phase_t;
    phase_t      ph_q, ph_d;
    logic [3:0]  cnt_q, cnt_d;
    logic        wr_q, wr_d, ack_q, ack_d, oe_q, oe_d;
    logic        ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
    logic [19:0] addr_q, addr_d;
    logic [15:0] wd_q, wd_d, rd_q, rd_d;

    always_comb
    begin
        ph_d = ph_q; cnt_d = cnt_q; wr_d = wr_q; ack_d = 1'b0; oe_d = oe_q;
        ce_n_d = ce_n_q; oe_n_d = oe_n_q; we_n_d = we_n_q;
        addr_d = addr_q; wd_d = wd_q; rd_d = rd_q;
        unique case (ph_q)
            P_IDLE:
                if (req)
                begin
                    addr_d = addr; wd_d = wdata; wr_d = wr;
                    ce_n_d = 1'b0; oe_d = wr;
                    cnt_d = 4'(SETUP_CYC - 1); ph_d = P_SETUP;
                end
            P_SETUP:
                if (cnt_q == 4'h0)
                begin
                    we_n_d = ~wr_q; oe_n_d = wr_q;
                    cnt_d = 4'(STROBE_CYC - 1); ph_d = P_STROBE;
                end
                else cnt_d = cnt_q - 4'h1;
            P_STROBE:
                if (cnt_q == 4'h0)
                begin
                    // release all three enables so the next read relatches status
                    if (!wr_q) rd_d = dq_in;
                    we_n_d = 1'b1; oe_n_d = 1'b1; ce_n_d = 1'b1;
                    cnt_d = 4'(GAP_CYC - 1); ph_d = P_GAP;
                end
                else cnt_d = cnt_q - 4'h1;
            P_GAP:
                if (cnt_q == 4'h0)
                begin
                    oe_d = 1'b0; ack_d = 1'b1; ph_d = P_IDLE;
                end
                else cnt_d = cnt_q - 4'h1;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ph_q <= P_IDLE; cnt_q <= 4'h0; wr_q <= 1'b0; ack_q <= 1'b0;
            oe_q <= 1'b0; ce_n_q <= 1'b1; oe_n_q <= 1'b1; we_n_q <= 1'b1;
            addr_q <= 20'h00000; wd_q <= 16'h0000; rd_q <= 16'h0000;
        end
        else
        begin
            ph_q <= ph_d; cnt_q <= cnt_d; wr_q <= wr_d; ack_q <= ack_d;
            oe_q <= oe_d; ce_n_q <= ce_n_d; oe_n_q <= oe_n_d; we_n_q <= we_n_d;
            addr_q <= addr_d; wd_q <= wd_d; rd_q <= rd_d;
        end
    end

    assign ack = ack_q; assign rdata = rd_q; assign pin_addr = addr_q;
    assign dq_out = wd_q; assign dq_oe = oe_q;
    assign ce_n = ce_n_q; assign oe_n = oe_n_q; assign we_n = we_n_q;

    oe_toggle_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(oe_n) |-> oe_n [*2])
        else $error("output enable not released between reads");
endmodule // flash_pin_cycle
`default_nettype wire

// [verification/flash_model.sv]
// behavioural parallel flash: command decode and operation status byte
// assumes pins sampled on the host core clock; addr bit 19 marks a locked block
`timescale 1ns/100ps
`default_nettype none
module flash_model
    import flash_host_pkg::*;
#(
    parameter int PROG_CYC = 200,
    parameter int SUSP_CYC = 80
)
(
    input  wire logic        core_clk,
    input  wire logic [19:0] flash_addr,
    input  wire logic [15:0] dq_out,
    input  wire logic        dq_oe,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        rp_n,
    input  wire logic        vpp_bad,
    output logic [15:0]      dq_in
);
    logic        vpp;
    logic        lock;
    logic        psusp;
    logic        rsv;
    logic        we_l;
    logic        oe_l;
    logic [1:0]  pend;
    int          cnt;
    int          scnt;
    logic [7:0]  lat;
    logic [15:0] last;
    logic [7:0]  stat_now;

    // erase suspend and erase/program failure are never raised by this model
    assign stat_now = {cnt == 0 || psusp, 3'h0, vpp, psusp, lock, rsv};

    // any address returns status; released bus shows the inverse of its last value
    always_comb
        dq_in = (!ce_n && !oe_n) ? {8'h00, oe_l ? stat_now : lat} : ~last;

    always @(posedge core_clk)
    begin
        we_l <= we_n;
        oe_l <= oe_n;
        rsv <= ~rsv;
        last <= dq_in;
        if (oe_l && !oe_n)
            lat <= stat_now;
        if (cnt != 0 && !psusp)
            cnt <= cnt - 1;
        if (scnt == 1 && cnt > 1)
            psusp <= 1'b1;
        if (scnt != 0)
            scnt <= (cnt > 1) ? scnt - 1 : 0;
        if (!we_l && we_n)
        begin
            pend <= 2'h0;
            if (pend != 2'h0)
            begin
                if (flash_addr[19])
                    lock <= 1'b1;
                else if (vpp_bad || vpp || lock)
                    vpp <= vpp | vpp_bad;
                else
                    cnt <= PROG_CYC * int'(pend);
            end
            else
                case (dq_out[7:0])
                    FL_CLR[7:0]:    {vpp, lock} <= 2'h0;
                    FL_PROG[7:0]:   pend <= 2'h1;
                    FL_ERASE[7:0]:  pend <= 2'h2;
                    FL_SUSP[7:0]:   scnt <= (cnt != 0) ? SUSP_CYC : 0;
                    FL_RESUME[7:0]: psusp <= 1'b0;
                    default:        pend <= 2'h0;
                endcase
        end
        if (!rp_n)
        begin
            {vpp, lock, psusp, rsv} <= 4'h0;
            {cnt, scnt, pend, last} <= '0;
        end
    end
endmodule // flash_model
`default_nettype wire

// [verification/test_flash_host.sv]
// self-checking bench for the flash host: software port, interrupt, flash model
// assumes the model treats flash address bit 19 as a locked block
`timescale 1ns/100ps
`default_nettype none
module test_flash_host
    import flash_host_pkg::*;
    ;
    logic        core_clk;
    logic        rst;
    logic        reg_wr;
    logic        reg_rd;
    logic        irq;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        rp_n;
    logic        vpp_bad;
    logic        rd_pend;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic [19:0] flash_addr;
    logic [15:0] dq_in;
    logic [15:0] dq_out;
    logic [31:0] exp_q[$];
    int          fails;
    int          check_count;
    int          seed;

    flash_host dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .flash_addr(flash_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n));

    flash_model flash (.core_clk(core_clk), .flash_addr(flash_addr), .dq_out(dq_out),
        .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n),
        .vpp_bad(vpp_bad), .dq_in(dq_in));

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic compare(input logic [31:0] got, input logic [31:0] want, input string what);
        check_count++;
        if (got !== want)
        begin
            fails++;
            $display("MISMATCH %0t %s got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // read answers are matched in order against the notes left by the driver
    always @(posedge core_clk)
    begin
        if (rd_pend && exp_q.size() != 0)
            compare(reg_rdata, exp_q.pop_front(), "read");
        rd_pend <= reg_rd;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic cmd(input logic [2:0] c);
        wr(REG_CMD, {29'h0, c});
    endtask

    // bounded wait; every event is unmasked while this is used
    task automatic op(input logic [2:0] c);
        int n;
        cmd(c);
        n = 0;
        while (irq !== 1'b1 && n < 3000)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n == 3000)
        begin
            fails++;
            $display("MISMATCH %0t no interrupt", $time);
        end
    endtask

    task automatic check(input logic [31:0] st, input logic [31:0] ev);
        rd(REG_STAT, st);
        rd(REG_IRQ, ev);
        wr(REG_IRQ, 32'h7);
    endtask

    initial
    begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, vpp_bad} = '0;
        {fails, check_count} = '0;
        seed = 32'hF453ED2A;
        rst = 1'b1;
        repeat (6) @(posedge core_clk);
        compare({31'h0, rp_n}, 32'h0, "reset pin");
        rst <= 1'b0;
        rd(REG_STAT, 32'h0);
        rd(REG_MASK, 32'h0);
        wr(8'h20, 32'hFFFF);
        rd(8'h20, 32'h0);
        wr(REG_MASK, 32'h7);
        rd(REG_MASK, 32'h7);
        $display("test reset done");
        for (int k = 0; k < 4; k++)
        begin
            wr(REG_ADDR, $random(seed) & 32'h0007FFFF);
            wr(REG_DATA, $random(seed) & 32'h0000FFFF);
            op(k[0] ? OP_ERASE : OP_PROG);
            check(32'h080, 32'h1);
        end
        $display("test program erase done");
        wr(REG_ADDR, 32'h80000);
        rd(REG_ADDR, 32'h80000);
        wr(REG_DATA, 32'h0000A5C3);
        rd(REG_DATA, 32'h0000A5C3);
        op(OP_PROG);
        check(32'h282, 32'h2);
        rd(REG_CMD, 32'h1);
        cmd(OP_CLEAR);
        repeat (20) @(posedge core_clk);
        wr(REG_IRQ, 32'h7);
        op(OP_RDSTAT);
        check(32'h080, 32'h1);
        $display("test locked block done");
        vpp_bad <= 1'b1;
        wr(REG_ADDR, 32'h0);
        op(OP_PROG);
        wr(REG_MASK, 32'h0);
        repeat (2) @(posedge core_clk);
        compare({31'h0, irq}, 32'h0, "masked irq");
        wr(REG_MASK, 32'h7);
        repeat (2) @(posedge core_clk);
        compare({31'h0, irq}, 32'h1, "unmasked irq");
        check(32'h288, 32'h2);
        vpp_bad <= 1'b0;
        op(OP_PROG);
        check(32'h080, 32'h1);
        $display("test supply fault done");
        for (int k = 0; k < 2; k++)
        begin
            cmd(OP_PROG);
            repeat (k ? 140 : 30) @(posedge core_clk);
            // address writes are dropped while an operation runs
            wr(REG_ADDR, 32'h80000);
            rd(REG_STAT, 32'h180);
            rd(REG_ADDR, 32'h0);
            op(OP_SUSP);
            check(k ? 32'h080 : 32'h084, k ? 32'h1 : 32'h4);
            if (k == 0)
            begin
                op(OP_RESUME);
                check(32'h080, 32'h1);
            end
        end
        $display("test suspend done");
        repeat (4) @(posedge core_clk);
        give_verdict();
    end

    initial
    begin
        #(50 * 30000);
        fails++;
        $display("MISMATCH %0t watchdog expired", $time);
        give_verdict();
    end
endmodule // test_flash_host
`default_nettype wire
